/* File: logic/ecc_bus_ctrl.sv */
// Overview of operation
// [R1] Cycle runs setup, delay, data setup, access, hold.
// [R2] Phase lengths come from per-select timing word.
// [R3] Setup 1-2 periods, plus 0-3 on window change.
// [R4] Command delay 0-3, data setup 0-1 periods.
// [R5] Access 1-32 periods, ready may stretch it.
// [R6] Hold phase lasts 0-3 periods.
// [R7] Read data latched at read strobe rise.
// [R8] Partner may drop data after strobe rise.
// [R9] Ready polarity chosen by configuration.
// [R10] Synchronous ready driven with reference clock.
// [R11] Asynchronous ready gets extra synchroniser stage.
// [R12] Asynchronous ready pulse lasts over one period.
// [R13] Inactive ready adds waitstate, active ends cycle.
// [R14] Partner may drop ready at strobe rise.
// [R15] Partner clears ready before next sample point.
// [R16] Finish running cycle before granting the bus.
// [R17] Release drives strobes inactive, then floats them.
// [R18] Only hold going high starts the regain.
// [R19] Master may return bus without our request.
// [R20] Regain drives strobes inactive before next cycle.
// [R21] All phases counted in reference clock periods.
`timescale 1ns/1ns
module ecc_bus_ctrl
    import ecc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [REG_AW-1:0] i_reg_addr,
    input  wire logic [REG_DW-1:0] i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [REG_DW-1:0] o_reg_rdata,
    input  wire logic              i_req,
    input  wire logic              i_req_write,
    input  wire logic              i_req_upper,
    input  wire logic              i_req_cs,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [DATA_W-1:0] i_req_wdata,
    output logic                   o_busy,
    output logic                   o_done,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_ref_clk,
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_addr_oe,
    output logic                   o_ale,
    output logic                   o_rd_n,
    output logic                   o_wr_n,
    output logic                   o_bhe_n,
    output logic      [DATA_W-1:0] o_data_out,
    output logic                   o_data_oe,
    input  wire logic [DATA_W-1:0] i_data_in,
    output logic                   o_ctrl_oe,
    input  wire logic              i_ready,
    input  wire logic              i_hold_n,
    output logic                   o_bus_release_acknowledge_n,
    output logic                   o_bus_regain_request_n
);

    localparam int SYNC_W = DATA_W + 2;

    typedef struct packed {
        ecc_state_type                   state;
        logic [CNT_W-1:0]                cnt;
        ecc_timing_type                  cfg_cur;
        ecc_timing_type [NUM_CS-1:0]     cfg_regs;
        ecc_req_type                     req;
        logic                            pending;
        logic                            busy;
        logic [0:0]                      last_cs;
        logic                            last_valid;
        logic                            ready_q;
        logic [1:0]                      rd_pipe;
        logic [DATA_W-1:0]               rdata;
        logic                            done;
        logic [REG_DW-1:0]               reg_rdata;
        ecc_pins_type                    pins;
    } ecc_st_type;

    ecc_st_type      st_ff;
    ecc_st_type      nxt_st;
    logic            tick;
    logic [SYNC_W-1:0] sync_out;
    logic [DATA_W-1:0] din_s;
    logic            ready_s;
    logic            hold_req;
    logic            ready_act;
    logic [CNT_W-1:0] ab_len;

    ecc_tick u_tick (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .o_ref_clk (o_ref_clk),
        .o_tick    (tick)
    );

    ecc_sync #(.W(SYNC_W)) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_hold_n, i_ready, i_data_in}),
        .o_sync    (sync_out)
    );

    assign din_s    = sync_out[DATA_W-1:0];
    assign ready_s  = sync_out[DATA_W];
    assign hold_req = !sync_out[DATA_W+1];

    function automatic logic [CNT_W-1:0] phase_len(input ecc_state_type s, input ecc_timing_type t);
        logic [CNT_W-1:0] len;
        len = '0;
        unique case (s)
            ST_C:    len = CNT_W'(t.cmd_delay);                 // [R4]
            ST_D:    len = CNT_W'(t.data_setup);                // [R4]
            ST_E:    len = CNT_W'(t.access_len) + ONE_TCP;      // [R5]
            ST_F:    len = CNT_W'(t.hold_len);                  // [R6]
            default: len = ONE_TCP;
        endcase
        return len;
    endfunction

    // Phases of zero length are skipped, so a cycle never spends a period in them.
    function automatic ecc_state_type next_phase(input ecc_state_type s, input ecc_timing_type t);
        ecc_state_type ns;
        ns = ST_IDLE;
        unique case (s)
            ST_AB:   ns = (t.cmd_delay != 2'h0) ? ST_C : (t.data_setup ? ST_D : ST_E);   // [R1]
            ST_C:    ns = t.data_setup ? ST_D : ST_E;                                    // [R1]
            ST_D:    ns = ST_E;                                                          // [R1]
            ST_E:    ns = (t.hold_len != 2'h0) ? ST_F : ST_IDLE;                         // [R1]
            default: ns = ST_IDLE;
        endcase
        return ns;
    endfunction

    // In asynchronous mode the sample comes from one more stage clocked per period,
    // which delays the ready sample by one period but tolerates any input timing.
    assign ready_act = ((st_ff.cfg_cur.ready_async ? st_ff.ready_q : ready_s)
                        == st_ff.cfg_cur.ready_pol);    // [R9] [R11]

    always_comb
    begin
        ecc_timing_type t;
        t = st_ff.cfg_regs[st_ff.req.cs];
        ab_len = t.ab_long ? AB_LONG : AB_SHORT;                                        // [R3]
        if (st_ff.last_valid && (st_ff.last_cs != st_ff.req.cs))
            ab_len = ab_len + CNT_W'(t.window_extra);                                   // [R3]
    end

    always_comb
    begin
        ecc_state_type ns;
        ns                = st_ff.state;
        nxt_st            = st_ff;
        nxt_st.done       = 1'b0;
        nxt_st.reg_rdata  = '0;
        nxt_st.rd_pipe    = {st_ff.rd_pipe[0], 1'b0};

        // Capture two clocks after the strobe rise: the pin synchroniser delays
        // the data by two clocks, so this is the level present at that edge.
        if (st_ff.rd_pipe[1])
        begin
            nxt_st.rdata = din_s;                                                   // [R7] [R8]
            nxt_st.done  = 1'b1;
            nxt_st.busy  = 1'b0;
        end

        if (i_reg_wr)
        begin
            if (i_reg_addr == REG_TIMING0)
                nxt_st.cfg_regs[0] = i_reg_wdata[15:0];                             // [R2]
            else if (i_reg_addr == REG_TIMING1)
                nxt_st.cfg_regs[1] = i_reg_wdata[15:0];                             // [R2]
        end
        if (i_reg_rd)
        begin
            if (i_reg_addr == REG_TIMING0)
                nxt_st.reg_rdata = REG_DW'(st_ff.cfg_regs[0]);
            else if (i_reg_addr == REG_TIMING1)
                nxt_st.reg_rdata = REG_DW'(st_ff.cfg_regs[1]);
            else if (i_reg_addr == REG_STATUS)
                nxt_st.reg_rdata = REG_DW'({st_ff.state, st_ff.pending, st_ff.busy, !st_ff.pins.bus_release_acknowledge_n});
        end

        if (i_req && !st_ff.busy)
        begin
            nxt_st.req     = '{write: i_req_write, upper: i_req_upper, cs: i_req_cs,
                               addr: i_req_addr, wdata: i_req_wdata};
            nxt_st.pending = 1'b1;
            nxt_st.busy    = 1'b1;
        end

        if (tick)
        begin
            nxt_st.ready_q = ready_s;                                               // [R11]
            unique case (st_ff.state)
                ST_IDLE:
                begin
                    if (hold_req)
                        ns = ST_RELEASE;                                            // [R16]
                    else if (st_ff.pending)
                    begin
                        ns                = ST_AB;
                        nxt_st.cfg_cur    = st_ff.cfg_regs[st_ff.req.cs];           // [R2]
                        nxt_st.cnt        = ab_len;                                 // [R3]
                        nxt_st.pending    = 1'b0;
                        nxt_st.last_cs    = st_ff.req.cs;
                        nxt_st.last_valid = 1'b1;
                    end
                end
                ST_AB, ST_C, ST_D, ST_E, ST_F:
                begin
                    if (st_ff.cnt > ONE_TCP)
                        nxt_st.cnt = st_ff.cnt - ONE_TCP;                           // [R21]
                    else if ((st_ff.state == ST_E) && st_ff.cfg_cur.ready_en && !ready_act)
                        nxt_st.cnt = ONE_TCP;                                       // [R13]
                    else
                    begin
                        ns         = next_phase(st_ff.state, st_ff.cfg_cur);        // [R13]
                        nxt_st.cnt = phase_len(ns, st_ff.cfg_cur);
                        if ((st_ff.state == ST_E) && !st_ff.req.write)
                            nxt_st.rd_pipe[0] = 1'b1;                               // [R7]
                        if ((ns == ST_IDLE) && st_ff.req.write)
                        begin
                            nxt_st.done = 1'b1;
                            nxt_st.busy = 1'b0;
                        end
                    end
                end
                ST_RELEASE:
                    ns = ST_HELD;                                                   // [R17]
                ST_HELD:
                begin
                    if (!hold_req)
                        ns = ST_REGAIN;                                             // [R18] [R19]
                end
                ST_REGAIN:
                    ns = ST_IDLE;                                                   // [R20]
                default:
                    ns = ST_IDLE;
            endcase
        end
        nxt_st.state = ns;

        // Pin levels follow the next phase, so every pin is a flip-flop output.
        nxt_st.pins.ale     = (ns == ST_AB);                                        // [R1]
        nxt_st.pins.rd_n    = !((ns == ST_E) && !st_ff.req.write);                  // [R1]
        nxt_st.pins.wr_n    = !((ns == ST_E) && st_ff.req.write);                   // [R1]
        nxt_st.pins.dout_oe = st_ff.req.write && ((ns == ST_D) || (ns == ST_E) || (ns == ST_F));
        nxt_st.pins.ctrl_oe = (ns != ST_HELD);                                      // [R17] [R20]
        nxt_st.pins.addr_oe = (ns != ST_HELD);
        nxt_st.pins.bus_release_acknowledge_n  = (ns != ST_HELD);
        nxt_st.pins.bus_regain_request_n  = !((ns == ST_HELD) && nxt_st.pending);
        if (ns == ST_AB && st_ff.state == ST_IDLE)
        begin
            nxt_st.pins.addr  = st_ff.req.addr;
            nxt_st.pins.dout  = st_ff.req.wdata;
            nxt_st.pins.bhe_n = !st_ff.req.upper;
        end
        else if (ns == ST_IDLE || ns == ST_RELEASE)
            nxt_st.pins.bhe_n = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_ff              <= '0;
            st_ff.state        <= ST_IDLE;
            st_ff.cfg_cur      <= TIMING_RST;
            st_ff.cfg_regs     <= {NUM_CS{TIMING_RST}};
            st_ff.pins.rd_n    <= 1'b1;
            st_ff.pins.wr_n    <= 1'b1;
            st_ff.pins.bhe_n   <= 1'b1;
            st_ff.pins.ctrl_oe <= 1'b1;
            st_ff.pins.addr_oe <= 1'b1;
            st_ff.pins.bus_release_acknowledge_n  <= 1'b1;
            st_ff.pins.bus_regain_request_n  <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign o_reg_rdata = st_ff.reg_rdata;
    assign o_busy      = st_ff.busy;
    assign o_done      = st_ff.done;
    assign o_rdata     = st_ff.rdata;
    assign o_addr      = st_ff.pins.addr;
    assign o_addr_oe   = st_ff.pins.addr_oe;
    assign o_ale       = st_ff.pins.ale;
    assign o_rd_n      = st_ff.pins.rd_n;
    assign o_wr_n      = st_ff.pins.wr_n;
    assign o_bhe_n     = st_ff.pins.bhe_n;
    assign o_data_out  = st_ff.pins.dout;
    assign o_data_oe   = st_ff.pins.dout_oe;
    assign o_ctrl_oe   = st_ff.pins.ctrl_oe;
    assign o_bus_release_acknowledge_n    = st_ff.pins.bus_release_acknowledge_n;
    assign o_bus_regain_request_n    = st_ff.pins.bus_regain_request_n;

    // Helper for the checks below: periods spent in the current state.
    logic [7:0] ph_ticks;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (st_ff.state != nxt_st.state))
            ph_ticks <= '0;
        else if (tick && (ph_ticks != 8'hff))
            ph_ticks <= ph_ticks + 1'b1;
    end

    sequence s_strobes_idle;
        o_ctrl_oe && !o_ale && o_rd_n && o_wr_n;
    endsequence

    sequence s_floated;
        !o_ctrl_oe && !o_bus_release_acknowledge_n;
    endsequence

    a_strobe_in_access: assert property (@(posedge i_clk) disable iff (i_sys_rst)   // [R1]
        (!o_rd_n || !o_wr_n) |-> (st_ff.state == ST_E))
        else $error("command strobe active outside access phase");

    a_ab_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)          // [R3]
        (st_ff.state == ST_AB && nxt_st.state != ST_AB) |-> (ph_ticks >= 8'h00 && ph_ticks <= 8'h04))
        else $error("address setup phase length out of range");

    a_cmd_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)         // [R4]
        (st_ff.state == ST_C && nxt_st.state != ST_C) |-> (ph_ticks + 8'h01 == 8'(st_ff.cfg_cur.cmd_delay)))
        else $error("command delay phase has wrong length");

    a_access_min: assert property (@(posedge i_clk) disable iff (i_sys_rst)         // [R5]
        (st_ff.state == ST_E && nxt_st.state != ST_E) |-> (ph_ticks >= 8'(st_ff.cfg_cur.access_len)))
        else $error("access phase shorter than programmed");

    a_hold_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)        // [R6]
        (st_ff.state == ST_F && nxt_st.state != ST_F) |-> (ph_ticks + 8'h01 == 8'(st_ff.cfg_cur.hold_len)))
        else $error("hold phase has wrong length");

    a_read_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst)         // [R7]
        $rose(o_rd_n) |-> ##2 (o_done && (o_rdata == $past(din_s))))
        else $error("read data not latched at strobe rise");

    a_ready_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst)         // [R13]
        (tick && st_ff.state == ST_E && st_ff.cnt == ONE_TCP && st_ff.cfg_cur.ready_en && !ready_act)
        |=> (st_ff.state == ST_E))
        else $error("inactive ready did not insert a waitstate");

    a_grant_after_cycle: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R16]
        $rose(st_ff.state == ST_RELEASE) |-> ($past(st_ff.state) == ST_IDLE))
        else $error("bus released during a running cycle");

    a_release_float: assert property (@(posedge i_clk) disable iff (i_sys_rst)      // [R17]
        $fell(o_bus_release_acknowledge_n) |-> s_floated and $past(o_ctrl_oe && !o_ale && o_rd_n && o_wr_n))
        else $error("strobes not driven inactive before floating");

    a_regain_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)       // [R18]
        (tick && st_ff.state == ST_HELD)
        |=> ($past(hold_req) ? (st_ff.state == ST_HELD) : (st_ff.state == ST_REGAIN)))
        else $error("regain not caused by hold release");

    a_regain_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)       // [R20]
        $rose(o_bus_release_acknowledge_n) |-> s_strobes_idle ##1 (st_ff.state == ST_REGAIN)[*6])
        else $error("strobes not driven inactive on regain");

endmodule

/* File: logic/ecc_pkg.sv */
package ecc_pkg;

    // Clocking: the bus runs in whole periods of the reference clock output.
    localparam int CLK_PERIOD_NS = 50;
    localparam int REF_PERIOD_NS = 400;
    localparam int TCP_CYCLES    = REF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TCP_HALF      = TCP_CYCLES / 2;
    localparam int DIV_W         = 4;

    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 16;
    localparam int REG_AW  = 8;
    localparam int REG_DW  = 32;
    localparam int NUM_CS  = 2;
    localparam int CNT_W   = 6;

    localparam logic [REG_AW-1:0] REG_TIMING0 = 8'h00;
    localparam logic [REG_AW-1:0] REG_TIMING1 = 8'h04;
    localparam logic [REG_AW-1:0] REG_STATUS  = 8'h08;

    localparam logic [CNT_W-1:0] AB_SHORT = 6'h01;
    localparam logic [CNT_W-1:0] AB_LONG  = 6'h02;
    localparam logic [CNT_W-1:0] ONE_TCP  = 6'h01;

    // Per chip select timing configuration, one 16-bit word.
    typedef struct packed {
        logic       ready_pol;
        logic       ready_async;
        logic       ready_en;
        logic [1:0] hold_len;
        logic [4:0] access_len;
        logic       data_setup;
        logic [1:0] cmd_delay;
        logic [1:0] window_extra;
        logic       ab_long;
    } ecc_timing_type;

    localparam logic [15:0] TIMING_RST = 16'h0000;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_AB      = 9'h002,
        ST_C       = 9'h004,
        ST_D       = 9'h008,
        ST_E       = 9'h010,
        ST_F       = 9'h020,
        ST_RELEASE = 9'h040,
        ST_HELD    = 9'h080,
        ST_REGAIN  = 9'h100
    } ecc_state_type;

    typedef struct packed {
        logic              write;
        logic              upper;
        logic [0:0]        cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ecc_req_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              addr_oe;
        logic              ale;
        logic              rd_n;
        logic              wr_n;
        logic              bhe_n;
        logic [DATA_W-1:0] dout;
        logic              dout_oe;
        logic              ctrl_oe;
        logic              bus_release_acknowledge_n;
        logic              bus_regain_request_n;
    } ecc_pins_type;

endpackage

/* File: logic/ecc_sync.sv */
`timescale 1ns/1ns
module ecc_sync
    import ecc_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ecc_sync_st_type;

    ecc_sync_st_type st_ff;
    ecc_sync_st_type nxt_st;

    // The first stage feeds the second stage only.
    always_comb
    begin
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign o_sync = st_ff.s2;

endmodule

/* File: logic/ecc_tick.sv */
`timescale 1ns/1ns
module ecc_tick
    import ecc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    output logic      o_ref_clk,
    output logic      o_tick
);

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TCP_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(TCP_HALF);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             ref_clk;
        logic             tick;
    } ecc_tick_st_type;

    ecc_tick_st_type st_ff;
    ecc_tick_st_type nxt_st;

    // The tick marks the rising edge of the reference clock, so every phase
    // boundary lines up with an edge that the outside world can see.
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.tick = (st_ff.cnt == DIV_LAST);
        if (st_ff.cnt == DIV_LAST)
            nxt_st.cnt = '0;
        else
            nxt_st.cnt = st_ff.cnt + 1'b1;
        nxt_st.ref_clk = (nxt_st.cnt < DIV_HALF);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign o_ref_clk = st_ff.ref_clk;
    assign o_tick    = st_ff.tick;

endmodule

/* File: tb/ecc_mem_model.sv */
`timescale 1ns/1ns
module ecc_mem_model
    import ecc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_rd_n,
    input  wire logic              i_wr_n,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [7:0]        i_rdy_delay,
    input  wire logic              i_rdy_pol,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_ready,
    output logic      [DATA_W-1:0] o_last_wdata
);
    logic [7:0] cnt_ff = 8'h00;
    logic       act_ff = 1'b0;
    initial o_rdata = 16'h0000;
    initial o_last_wdata = 16'h0000;
    assign o_ready = i_rdy_pol ? act_ff : !act_ff;
    always @(posedge i_clk)
    begin
        // Released data toggles so a late latch cannot pass by luck.
        o_rdata <= !i_rd_n ? (i_addr[15:0] ^ 16'h5a5a) : ~o_rdata;
        if (!i_wr_n)
            o_last_wdata <= i_wdata;
        // Ready rises i_rdy_delay+1 clocks into the strobe, stays up and drops at its end.
        if (i_rd_n && i_wr_n)
        begin
            cnt_ff <= 8'h00;
            act_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 8'h01;
            act_ff <= act_ff || (cnt_ff >= i_rdy_delay);
        end
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import ecc_pkg::*;
    logic              clk = 1'b0, rst = 1'b1, rwr = 1'b0, rrd = 1'b0, req = 1'b0;
    logic              rw = 1'b0, up = 1'b0, cs = 1'b0, hold_n = 1'b1, pol = 1'b1;
    logic [REG_AW-1:0] ra = 8'h00;
    logic [REG_DW-1:0] rwd = 32'h0, rdat, v;
    logic [ADDR_W-1:0] addr = 24'h0, a_o;
    logic [DATA_W-1:0] wd = 16'h0, rdata, dout, pin_d, mem_w, bus;
    logic [7:0]        dly = 8'h00;
    logic              busy, done, rclk, aoe, ale, rd_n, wr_n, bhe_n, doe, coe, rdy, bus_release_acknowledge_n, bus_regain_request_n;
    logic [31:0]       seed = 32'h00004f86;
    int                err_total = 0, compares = 0, n;
    assign bus = doe ? dout : pin_d;
    initial forever #25 clk = ~clk;
    ecc_bus_ctrl ecc_bus_ctrl_inst (.i_clk(clk), .i_sys_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rwd),
        .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdat), .i_req(req), .i_req_write(rw), .i_req_upper(up),
        .i_req_cs(cs), .i_req_addr(addr), .i_req_wdata(wd), .o_busy(busy), .o_done(done), .o_rdata(rdata),
        .o_ref_clk(rclk), .o_addr(a_o), .o_addr_oe(aoe), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_bhe_n(bhe_n), .o_data_out(dout), .o_data_oe(doe), .i_data_in(bus), .o_ctrl_oe(coe), .i_ready(rdy),
        .i_hold_n(hold_n), .o_bus_release_acknowledge_n(bus_release_acknowledge_n), .o_bus_regain_request_n(bus_regain_request_n));
    ecc_mem_model ecc_mem_model_inst (.i_clk(clk), .i_addr(a_o), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_wdata(bus),
        .i_rdy_delay(dly), .i_rdy_pol(pol), .o_rdata(pin_d), .o_ready(rdy), .o_last_wdata(mem_w));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_w(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge clk);
        ra <= a; rwd <= d; rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic reg_r(input logic [REG_AW-1:0] a);
        @(posedge clk);
        ra <= a; rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        @(negedge clk);
        v = rdat;
    endtask
    // Waits at falling edges for one of the watched conditions; n returns the count of edges.
    task automatic wait_for(input int sel, input int lim);
        logic hit;
        n = 0;
        do
        begin
            @(negedge clk);
            hit = (sel == 0) ? (ale === 1'b1) : (sel == 1) ? (done === 1'b1) : (sel == 2) ? (bus_release_acknowledge_n === 1'b0)
                : (sel == 3) ? (bus_release_acknowledge_n === 1'b1) : (bus_regain_request_n === 1'b0);
            n++;
        end
        while (!hit && n < lim);
        if (!hit)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, sel, lim);
        end
    endtask
    task automatic start(input logic w, input logic c);
        @(posedge clk);
        v = rnd();
        req <= 1'b1; rw <= w; cs <= c; up <= v[31]; addr <= v[23:0]; wd <= v[31:16];
        @(posedge clk);
        req <= 1'b0;
    endtask
    task automatic run(input logic w, input logic c, input logic [15:0] tw, input int d, input logic p, input int len);
        pol <= p;
        dly <= d[7:0];
        reg_w(c ? REG_TIMING1 : REG_TIMING0, {16'h0000, tw});
        start(w, c);
        wait_for(0, 40);
        chk({a_o, bhe_n, rclk}, {addr, !up, 1'b1});
        wait_for(1, 2000);
        chk(n, len);
        chk(busy, 1'b0);
        if (w)
            chk(mem_w, wd);
        else
            chk(rdata, addr[15:0] ^ 16'h5a5a);
        $display("test cycle w=%0d cs=%0d done", w, c);
    endtask
    task automatic final_report();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        reg_r(REG_TIMING0); chk(v, 32'h0);
        reg_r(8'h0c); chk(v, 32'h0);
        reg_w(REG_TIMING1, 32'h0000a5c3);
        reg_r(REG_TIMING1); chk(v, 32'h0000a5c3);
        $display("test registers done");
        run(1'b0, 1'b0, 16'h0000, 0, 1'b1, 18);
        run(1'b1, 1'b1, 16'h1fff, 0, 1'b1, 352);
        run(1'b0, 1'b1, 16'h1fff, 0, 1'b1, 306);
        run(1'b0, 1'b0, 16'ha000, 12, 1'b1, 26);
        run(1'b1, 1'b0, 16'h6000, 0, 1'b0, 24);
        reg_w(REG_TIMING0, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            start(1'b0, 1'b0);
            wait_for(0, 40);
            @(posedge clk);
            hold_n <= 1'b0;
            wait_for(1, 200);
            wait_for(2, 200);
            chk({coe, aoe, doe}, 3'b000);
            reg_r(REG_STATUS);
            chk(v, 32'h00000401);
            if (k == 0)
            begin
                start(1'b0, 1'b0);
                wait_for(4, 40);
                repeat (24) @(negedge clk);
                chk(bus_release_acknowledge_n, 1'b0);
            end
            @(posedge clk);
            hold_n <= 1'b1;
            wait_for(3, 100);
            chk({coe, ale}, 2'b10);
            if (k == 0)
            begin
                wait_for(1, 200);
                chk(rdata, addr[15:0] ^ 16'h5a5a);
            end
            $display("test arbitration %0d done", k);
        end
        final_report();
    end
    initial
    begin
        #600000;
        err_total++;
        final_report();
    end
endmodule
